// file: rtl/mil_pkg.sv
/*
 * constants and carrier types for the interrupt request logic.
 * assumes a single core clock and an avalon-mm register port.
 */
`default_nettype none
package mil_pkg;
   // ==========================================================
   // register byte offsets
   localparam logic [4:0] MIL_OFF_CTRL = 5'h00;
   localparam logic [4:0] MIL_OFF_OPTION = 5'h04;
   localparam logic [4:0] MIL_OFF_FLAG_A = 5'h08;
   localparam logic [4:0] MIL_OFF_FLAG_B = 5'h0c;
   localparam logic [4:0] MIL_OFF_MASK_A = 5'h10;
   localparam logic [4:0] MIL_OFF_MASK_B = 5'h14;
   localparam logic [4:0] MIL_OFF_STATUS = 5'h18;
   // ==========================================================
   // irq_control_reg field positions and option register edge bit
   localparam int MIL_CTRL_GIE = 7;
   localparam int MIL_CTRL_PGE = 6;
   localparam int MIL_CTRL_TICK_MASK = 5;
   localparam int MIL_CTRL_EXT_MASK = 4;
   localparam int MIL_CTRL_PORT_MASK = 3;
   localparam int MIL_CTRL_TICK_FLAG = 2;
   localparam int MIL_CTRL_EXT_FLAG = 1;
   localparam int MIL_CTRL_PORT_FLAG = 0;
   localparam int MIL_OPT_EDGE = 6;
   // ==========================================================
   // status register field positions
   localparam int MIL_STAT_REQ = 0;
   localparam int MIL_STAT_WAKE = 1;
   localparam int MIL_STAT_SLEEP = 2;
   localparam int MIL_STAT_GIE = 3;
   // ==========================================================
   // widths
   localparam int MIL_CORE_W = 3;
   localparam int MIL_PFA_W = 8;
   localparam int MIL_PFB_W = 4;
   localparam int MIL_UPPER_W = 4;
   localparam int MIL_SYNC_W = 5;
   // ==========================================================
   // reset values
   localparam logic [7:0] MIL_CTRL_RST = 8'h00;
   localparam logic [7:0] MIL_OPTION_RST = 8'hff;
   localparam logic [7:0] MIL_MASK_A_RST = 8'h00;
   localparam logic [3:0] MIL_MASK_B_RST = 4'h0;
   // ==========================================================
   // fixed values
   localparam logic [12:0] MIL_VECTOR = 13'h0004;
   localparam logic [7:0] MIL_TICK_MAX = 8'hff;
   localparam logic [7:0] MIL_TICK_ZERO = 8'h00;
   // ==========================================================
   // carriers
   typedef struct packed {
      logic read;
      logic write;
      logic [4:0] address;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } mil_avs_req_t;
   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } mil_avs_rsp_t;
   typedef struct packed {
      logic take;
      logic clear_gie;
      logic push_ret;
      logic [12:0] vector;
   } mil_core_cmd_t;
endpackage
`default_nettype wire

// file: rtl/mil_pin_sync.sv
/*
 * three-flop synchroniser with agreement filter for pin inputs.
 * assumes asynchronous inputs; outputs one-cycle rise and fall pulses.
 */
`timescale 1ns/1ns
`default_nettype none
module mil_pin_sync #(
   parameter int W = 1
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] level_o,
   output logic [W-1:0] rise_o,
   output logic [W-1:0] fall_o
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] lvl_r;
   logic [W-1:0] agree;
   // ==========================================================
   // sync chain; the first stage feeds only the second
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= pin_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   // ==========================================================
   // a change counts once stages two and three agree
   assign agree = ~(s2_r ^ s3_r);
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         lvl_r <= '0;
      end else begin
         lvl_r <= (agree & s3_r) | (~agree & lvl_r);
      end
   end
   assign rise_o = agree & s3_r & ~lvl_r;
   assign fall_o = agree & ~s3_r & lvl_r;
   assign level_o = lvl_r;
endmodule // mil_pin_sync
`default_nettype wire

// file: rtl/mil_flag_cell.sv
/*
 * bank of sticky request flags, hardware set wins over software write.
 * assumes set pulses and write strobe on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
module mil_flag_cell #(
   parameter int W = 1
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic [W-1:0] set_i,
   input wire logic wr_i,
   input wire logic [W-1:0] wdata_i,
   output logic [W-1:0] flag_o
);
   logic [W-1:0] flag_r;
   logic [W-1:0] flag_nxt;
   // ==========================================================
   // set beats a same-cycle clear
   always_comb begin
      flag_nxt = wr_i ? wdata_i : flag_r;
      flag_nxt = flag_nxt | set_i;
   end
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         flag_r <= '0;
      end else begin
         flag_r <= flag_nxt;
      end
   end
   assign flag_o = flag_r;
endmodule // mil_flag_cell
`default_nettype wire

// file: rtl/mil_irq_logic.sv
/*
 * interrupt request logic for an 8-bit core: flags, masks, enables,
 * pin edge and port change detection, entry and return handling.
 * assumes the core clock is the instruction clock, the core sequencer
 * acts on the take pulse at once, and software drives avalon-mm.
 */
// Summary of operation
// - fifteen sources, each with flag and enable
// - flags set regardless of any enable
// - global enable bit 7 gates all requests
// - enabled flag with global enable vectors immediately while the core is awake
// - reset clears the global enable
// - return operation sets the global enable again
// - entry clears enable, pushes return, vector 0004h
// - peripheral flags, masks, group enable gate them
// - pin events vector in three or four cycles
// - pin edge chosen by option bit 6
// - selected pin edge sets control bit 1
// - pin mask bit 4 clear blocks pin request, flag still sets
// - enabled pin event wakes core from sleep
// - timer rollover sets bit 2, mask bit 5
// - upper port change sets bit 0, masked
// - hardware saves only the return address
// - enabled request wakes even without global enable
`timescale 1ns/1ns
`default_nettype none
module mil_irq_logic
   import mil_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire mil_avs_req_t avs_req_i,
   output var mil_avs_rsp_t avs_rsp_o,
   input wire logic ext_irq_pin_i,
   input wire logic [MIL_UPPER_W-1:0] upper_port_pins_i,
   input wire logic [7:0] timer_zero_count_i,
   input wire logic [MIL_PFA_W-1:0] periph_evt_a_i,
   input wire logic [MIL_PFB_W-1:0] periph_evt_b_i,
   input wire logic return_from_irq_op_i,
   input wire logic core_sleeping_i,
   output var mil_core_cmd_t core_cmd_o,
   output var logic irq_request_o,
   output var logic wake_o
);
   // ==========================================================
   // declarations
   logic wreq_r;
   logic [31:0] rdata_r;
   logic [7:0] rd_mux;
   logic acc_wr;
   logic req_rd;
   logic wr_ctrl;
   logic wr_option;
   logic wr_flag_a;
   logic wr_flag_b;
   logic wr_mask_a;
   logic wr_mask_b;
   logic [7:0] wbyte;
   logic global_irq_enable_r;
   logic periph_group_enable_r;
   logic [2:0] core_mask_r;
   logic [7:0] option_r;
   logic [MIL_PFA_W-1:0] periph_mask_reg_a_r;
   logic [MIL_PFB_W-1:0] periph_mask_reg_b_r;
   logic [MIL_CORE_W-1:0] core_flag;
   logic [MIL_CORE_W-1:0] core_set;
   logic [MIL_PFA_W-1:0] periph_flag_reg_a;
   logic [MIL_PFB_W-1:0] periph_flag_reg_b;
   logic [MIL_SYNC_W-1:0] sync_lvl;
   logic [MIL_SYNC_W-1:0] sync_rise;
   logic [MIL_SYNC_W-1:0] sync_fall;
   logic ext_edge_select;
   logic ext_edge_evt;
   logic port_change_evt;
   logic [7:0] tick_prev_r;
   logic tick_overflow_evt;
   logic [7:0] irq_control_reg;
   logic core_hot;
   logic periph_hot;
   logic any_hot;
   logic take_nxt;
   logic take_r;
   logic irq_request_r;
   logic wake_r;
   // ==========================================================
   // avalon slave handshake: one wait state per access
   assign req_rd = avs_req_i.read;
   assign acc_wr = avs_req_i.write & ~wreq_r & avs_req_i.byteenable[0];
   assign wbyte = avs_req_i.writedata[7:0];
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         wreq_r <= 1'b1;
      end else begin
         wreq_r <= ~((avs_req_i.read | avs_req_i.write) & wreq_r);
      end
   end
   assign wr_ctrl = acc_wr & (avs_req_i.address == MIL_OFF_CTRL);
   assign wr_option = acc_wr & (avs_req_i.address == MIL_OFF_OPTION);
   assign wr_flag_a = acc_wr & (avs_req_i.address == MIL_OFF_FLAG_A);
   assign wr_flag_b = acc_wr & (avs_req_i.address == MIL_OFF_FLAG_B);
   assign wr_mask_a = acc_wr & (avs_req_i.address == MIL_OFF_MASK_A);
   assign wr_mask_b = acc_wr & (avs_req_i.address == MIL_OFF_MASK_B);
   // ==========================================================
   // read mux; unmapped offsets read zero
   assign irq_control_reg = {global_irq_enable_r,
                             periph_group_enable_r,
                             core_mask_r,
                             core_flag};
   always_comb begin
      rd_mux = 8'h00;
      unique case (avs_req_i.address)
         MIL_OFF_CTRL: begin
            rd_mux = irq_control_reg;
         end
         MIL_OFF_OPTION: begin
            rd_mux = option_r;
         end
         MIL_OFF_FLAG_A: begin
            rd_mux = periph_flag_reg_a;
         end
         MIL_OFF_FLAG_B: begin
            rd_mux = {4'h0, periph_flag_reg_b};
         end
         MIL_OFF_MASK_A: begin
            rd_mux = periph_mask_reg_a_r;
         end
         MIL_OFF_MASK_B: begin
            rd_mux = {4'h0, periph_mask_reg_b_r};
         end
         MIL_OFF_STATUS: begin
            rd_mux = 8'h00;
            rd_mux[MIL_STAT_REQ] = irq_request_r;
            rd_mux[MIL_STAT_WAKE] = wake_r;
            rd_mux[MIL_STAT_SLEEP] = core_sleeping_i;
            rd_mux[MIL_STAT_GIE] = global_irq_enable_r;
         end
         default: begin
            rd_mux = 8'h00;
         end
      endcase
   end
   // read data captured at the first edge, stands at the accept edge
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         rdata_r <= 32'h0000_0000;
      end else if (req_rd & wreq_r) begin
         rdata_r <= {24'h00_0000, rd_mux};
      end
   end
   assign avs_rsp_o.readdata = rdata_r;
   assign avs_rsp_o.waitrequest = wreq_r;
   // ==========================================================
   // pin synchronisers: bit 0 external pin, bits 4:1 upper port
   mil_pin_sync #(
      .W(MIL_SYNC_W)
   ) u_pin_sync (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .pin_i({upper_port_pins_i, ext_irq_pin_i}),
      .level_o(sync_lvl),
      .rise_o(sync_rise),
      .fall_o(sync_fall)
   );
   // ==========================================================
   // event detection
   assign ext_edge_select = option_r[MIL_OPT_EDGE];
   assign ext_edge_evt = ext_edge_select ? sync_rise[0] : sync_fall[0];
   assign port_change_evt = |(sync_rise[MIL_SYNC_W-1:1] | sync_fall[MIL_SYNC_W-1:1]);
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         tick_prev_r <= MIL_TICK_ZERO;
      end else begin
         tick_prev_r <= timer_zero_count_i;
      end
   end
   assign tick_overflow_evt = (tick_prev_r == MIL_TICK_MAX) &
                              (timer_zero_count_i == MIL_TICK_ZERO);
   // ==========================================================
   // request flags; set regardless of any enable
   assign core_set = {tick_overflow_evt, ext_edge_evt, port_change_evt};
   mil_flag_cell #(
      .W(MIL_CORE_W)
   ) u_core_flags (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .set_i(core_set),
      .wr_i(wr_ctrl),
      .wdata_i(wbyte[MIL_CORE_W-1:0]),
      .flag_o(core_flag)
   );
   mil_flag_cell #(
      .W(MIL_PFA_W)
   ) u_periph_flags_a (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .set_i(periph_evt_a_i),
      .wr_i(wr_flag_a),
      .wdata_i(wbyte),
      .flag_o(periph_flag_reg_a)
   );
   mil_flag_cell #(
      .W(MIL_PFB_W)
   ) u_periph_flags_b (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .set_i(periph_evt_b_i),
      .wr_i(wr_flag_b),
      .wdata_i(wbyte[MIL_PFB_W-1:0]),
      .flag_o(periph_flag_reg_b)
   );
   // ==========================================================
   // enables and option register
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         core_mask_r <= MIL_CTRL_RST[MIL_CTRL_TICK_MASK:MIL_CTRL_PORT_MASK];
         periph_group_enable_r <= MIL_CTRL_RST[MIL_CTRL_PGE];
      end else if (wr_ctrl) begin
         core_mask_r <= wbyte[MIL_CTRL_TICK_MASK:MIL_CTRL_PORT_MASK];
         periph_group_enable_r <= wbyte[MIL_CTRL_PGE];
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         option_r <= MIL_OPTION_RST;
      end else if (wr_option) begin
         option_r <= wbyte;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         periph_mask_reg_a_r <= MIL_MASK_A_RST;
         periph_mask_reg_b_r <= MIL_MASK_B_RST;
      end else begin
         if (wr_mask_a) begin
            periph_mask_reg_a_r <= wbyte;
         end
         if (wr_mask_b) begin
            periph_mask_reg_b_r <= wbyte[MIL_PFB_W-1:0];
         end
      end
   end
   // ==========================================================
   // global enable: entry clears, return sets, then software
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         global_irq_enable_r <= MIL_CTRL_RST[MIL_CTRL_GIE];
      end else if (take_nxt) begin
         global_irq_enable_r <= 1'b0;
      end else if (return_from_irq_op_i) begin
         global_irq_enable_r <= 1'b1;
      end else if (wr_ctrl) begin
         global_irq_enable_r <= wbyte[MIL_CTRL_GIE];
      end
   end
   // ==========================================================
   // request combine; same-cycle set pulses count so pin events
   // reach the core one edge sooner
   assign core_hot = |((core_flag | core_set) & core_mask_r);
   assign periph_hot = periph_group_enable_r &
                       (|((periph_flag_reg_a | periph_evt_a_i) & periph_mask_reg_a_r) |
                        |((periph_flag_reg_b | periph_evt_b_i) & periph_mask_reg_b_r));
   assign any_hot = core_hot | periph_hot;
   // no further take until the return op or a control write re-arms the enable
   assign take_nxt = global_irq_enable_r & any_hot & ~core_sleeping_i &
                     ~take_r;
   // ==========================================================
   // entry command, request level and wake
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         take_r <= 1'b0;
      end else begin
         take_r <= take_nxt;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         irq_request_r <= 1'b0;
      end else begin
         irq_request_r <= global_irq_enable_r & any_hot;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         wake_r <= 1'b0;
      end else begin
         wake_r <= core_sleeping_i & any_hot;
      end
   end
   // only the return address is pushed; no other context is saved
   assign core_cmd_o.take = take_r;
   assign core_cmd_o.clear_gie = take_r;
   assign core_cmd_o.push_ret = take_r;
   assign core_cmd_o.vector = MIL_VECTOR;
   assign irq_request_o = irq_request_r;
   assign wake_o = wake_r;
endmodule // mil_irq_logic
`default_nettype wire

// file: tb/mil_irq_chk.sv
/*
 * port assertions for the interrupt request logic.
 * bound to every mil_irq_logic instance; single core clock.
 */
`timescale 1ns/1ns
`default_nettype none
module mil_irq_chk
   import mil_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire mil_avs_req_t avs_req_i,
   input wire mil_avs_rsp_t avs_rsp_o,
   input wire logic return_from_irq_op_i,
   input wire logic core_sleeping_i,
   input wire mil_core_cmd_t core_cmd_o,
   input wire logic wake_o,
   input wire logic irq_request_o
);
   // ==========================================================
   // assertions
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_b_i);
   a_reset_quiets_outputs: assert property (disable iff (1'b0) !rst_b_i |=> !core_cmd_o.take && avs_rsp_o.waitrequest)
      else $error("outputs active after reset edge");
   a_take_one_pulse: assert property (core_cmd_o.take |=> !core_cmd_o.take)
      else $error("take wider than one cycle");
   a_cmd_fields_agree: assert property (core_cmd_o.clear_gie == core_cmd_o.take && core_cmd_o.push_ret == core_cmd_o.take)
      else $error("clear and push disagree with take");
   a_vector_fixed: assert property (core_cmd_o.take |-> core_cmd_o.vector == 13'h0004)
      else $error("wrong vector on take");
   a_gie_blocks_take: assert property (core_cmd_o.take && !return_from_irq_op_i ##1 !return_from_irq_op_i |=> !core_cmd_o.take)
      else $error("take while global enable clear");
   a_asleep_no_take: assert property (core_cmd_o.take |-> !$past(core_sleeping_i))
      else $error("take while core asleep");
   a_wake_needs_sleep: assert property (wake_o |-> $past(core_sleeping_i))
      else $error("wake while core awake");
   a_take_has_request: assert property (core_cmd_o.take |-> irq_request_o)
      else $error("take without request level");
   a_bus_one_wait: assert property ((avs_req_i.read || avs_req_i.write) && avs_rsp_o.waitrequest |=> !avs_rsp_o.waitrequest)
      else $error("bus answer late");
   a_bus_wait_rearm: assert property (!avs_rsp_o.waitrequest |=> avs_rsp_o.waitrequest)
      else $error("waitrequest low two cycles");
   a_bus_wait_cause: assert property ($fell(avs_rsp_o.waitrequest) |-> $past(avs_req_i.read) || $past(avs_req_i.write))
      else $error("answer without request");
endmodule // mil_irq_chk
bind mil_irq_logic mil_irq_chk u_chk (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .avs_req_i(avs_req_i),
   .avs_rsp_o(avs_rsp_o), .return_from_irq_op_i(return_from_irq_op_i), .core_sleeping_i(core_sleeping_i),
   .core_cmd_o(core_cmd_o), .wake_o(wake_o), .irq_request_o(irq_request_o));
`default_nettype wire

// file: tb/mil_core_model.sv
/*
 * core sequencer model: answers each accepted interrupt with a return.
 * assumes take is a one-cycle pulse on the core clock.
 */
`timescale 1ns/1ns
`default_nettype none
module mil_core_model
   import mil_pkg::*;
#(
   parameter int SVC = 16
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire mil_core_cmd_t cmd_i,
   output logic ret_o
);
   int cnt;
   // ==========================================================
   // service routine timer
   always_ff @(posedge clk_sys_i) begin
      ret_o <= 1'b0;
      if (!rst_b_i) begin
         cnt <= 0;
      end else if (cmd_i.push_ret) begin
         cnt <= SVC; // only the return address is stacked
      end else if (cnt == 1) begin
         ret_o <= 1'b1; // return re-arms the global enable
         cnt <= 0;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
endmodule // mil_core_model
`default_nettype wire

// file: tb/mil_irq_logic_test.sv
/*
 * self-checking bench for the interrupt request logic.
 * drives avalon-mm, pins, timer and peripheral events; core model answers.
 */
`timescale 1ns/1ns
`default_nettype none
module mil_irq_logic_test;
   import mil_pkg::*;
   logic clk_sys_i;
   logic rst_b_i = 1'b0;
   mil_avs_req_t req = '0;
   mil_avs_rsp_t rsp;
   logic pin = 1'b0;
   logic [3:0] port = 4'h0;
   logic [7:0] tmr = 8'h00;
   logic [7:0] pa = 8'h00;
   logic [3:0] pb = 4'h0;
   logic sleep = 1'b0;
   mil_core_cmd_t cmd;
   logic ret;
   logic wake;
   logic irq;
   logic [7:0] rnd = 8'h06;
   logic [7:0] b;
   logic [31:0] expq[$];
   int errors = 0;
   int checks = 0;
   int takes = 0;
   int cyc = 0;
   int n;
   mil_irq_logic DUT (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .avs_req_i(req), .avs_rsp_o(rsp),
      .ext_irq_pin_i(pin), .upper_port_pins_i(port), .timer_zero_count_i(tmr), .periph_evt_a_i(pa),
      .periph_evt_b_i(pb), .return_from_irq_op_i(ret), .core_sleeping_i(sleep), .core_cmd_o(cmd),
      .irq_request_o(irq), .wake_o(wake));
   mil_core_model u_core (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .cmd_i(cmd), .ret_o(ret));
   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   // ==========================================================
   // helpers
   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      req.read <= !wr;
      req.write <= wr;
      req.address <= a;
      req.byteenable <= 4'hf;
      req.writedata <= {24'h0, d};
      @(posedge clk_sys_i);
      while (rsp.waitrequest !== 1'b0) @(posedge clk_sys_i);
      req.read <= 1'b0;
      req.write <= 1'b0;
   endtask
   task rd(input logic [4:0] a, input logic [7:0] e);
      expq.push_back({24'h0, e});
      bus(1'b0, a, 8'h00);
   endtask
   task drive_pin(input logic v);
      @(posedge clk_sys_i);
      pin <= v;
      repeat (6) @(posedge clk_sys_i);
   endtask
   // cycles from a pin change to the take pulse, 10 when none
   task lat(input logic e, input logic [3:0] p);
      n = 0;
      @(posedge clk_sys_i);
      pin <= e;
      port <= p;
      do begin
         @(posedge clk_sys_i);
         #1;
         n++;
      end while (cmd.take !== 1'b1 && n < 10);
   endtask
   task test_done;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // ==========================================================
   // result monitor and timeout
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cmd.take === 1'b1) takes++;
      if (req.read && rsp.waitrequest === 1'b0) begin
         if (expq.size() == 0) chk("unexpected read", 32'h0, 32'h1);
         else chk($sformatf("read %h", req.address), expq.pop_front(), rsp.readdata);
      end
      if (cyc == 5000) begin
         errors++;
         test_done();
      end
   end
   // ==========================================================
   // scenarios
   initial begin
      repeat (3) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      rd(MIL_OFF_CTRL, 8'h00);
      rd(MIL_OFF_OPTION, 8'hff);
      rd(5'h1c, 8'h00);
      rnd = lfsr(rnd);
      bus(1'b1, MIL_OFF_MASK_B, rnd);
      rd(MIL_OFF_MASK_B, {4'h0, rnd[3:0]});
      b = 8'h01 << rnd[2:0];
      @(posedge clk_sys_i);
      pa <= b;
      pb <= rnd[7:4];
      @(posedge clk_sys_i);
      pa <= 8'h00;
      pb <= 4'h0;
      rd(MIL_OFF_FLAG_A, b);
      rd(MIL_OFF_FLAG_B, {4'h0, rnd[7:4]});
      bus(1'b1, MIL_OFF_MASK_B, 8'h00);
      bus(1'b1, MIL_OFF_MASK_A, b);
      rd(MIL_OFF_MASK_A, b);
      bus(1'b1, MIL_OFF_CTRL, 8'h80);
      repeat (3) @(posedge clk_sys_i);
      chk("takes", 0, takes);
      bus(1'b1, MIL_OFF_CTRL, 8'hc0);
      repeat (3) @(posedge clk_sys_i);
      chk("takes", 1, takes);
      rd(MIL_OFF_CTRL, 8'h40);
      bus(1'b1, MIL_OFF_FLAG_A, 8'h00);
      repeat (20) @(posedge clk_sys_i);
      rd(MIL_OFF_CTRL, 8'hc0);
      @(posedge clk_sys_i);
      tmr <= 8'hff;
      @(posedge clk_sys_i);
      tmr <= 8'h00;
      rd(MIL_OFF_CTRL, 8'hc4);
      bus(1'b1, MIL_OFF_CTRL, 8'ha0);
      @(posedge clk_sys_i);
      tmr <= 8'hff;
      @(posedge clk_sys_i);
      tmr <= 8'h00;
      repeat (3) @(posedge clk_sys_i);
      chk("takes", 2, takes);
      bus(1'b1, MIL_OFF_CTRL, 8'h20);
      repeat (20) @(posedge clk_sys_i);
      rd(MIL_OFF_CTRL, 8'ha0);
      for (int e = 1; e >= 0; e--) begin
         bus(1'b1, MIL_OFF_CTRL, 8'h00);
         bus(1'b1, MIL_OFF_OPTION, e ? 8'hff : 8'hbf);
         drive_pin(1'b1);
         rd(MIL_OFF_CTRL, e ? 8'h02 : 8'h00);
         bus(1'b1, MIL_OFF_CTRL, 8'h00);
         drive_pin(1'b0);
         rd(MIL_OFF_CTRL, e ? 8'h00 : 8'h02);
      end
      bus(1'b1, MIL_OFF_OPTION, 8'hff);
      bus(1'b1, MIL_OFF_CTRL, 8'h80);
      drive_pin(1'b1);
      chk("takes", 2, takes);
      bus(1'b1, MIL_OFF_CTRL, 8'h90);
      drive_pin(1'b0);
      lat(1'b1, port);
      chk("pin latency ok", 1, n == 3 || n == 4);
      bus(1'b1, MIL_OFF_CTRL, 8'h10);
      repeat (20) @(posedge clk_sys_i);
      rd(MIL_OFF_CTRL, 8'h90);
      bus(1'b1, MIL_OFF_CTRL, 8'h88);
      rnd = lfsr(rnd);
      lat(pin, port ^ (4'h1 << rnd[1:0]));
      chk("port latency ok", 1, n == 3 || n == 4);
      rd(MIL_OFF_CTRL, 8'h09);
      bus(1'b1, MIL_OFF_CTRL, 8'h08);
      repeat (20) @(posedge clk_sys_i);
      bus(1'b1, MIL_OFF_CTRL, 8'h08);
      @(posedge clk_sys_i);
      sleep <= 1'b1;
      rnd = lfsr(rnd);
      lat(pin, port ^ (4'h1 << rnd[1:0]));
      chk("wake", 1, wake);
      rd(MIL_OFF_STATUS, 8'h06);
      chk("irq request", 0, irq);
      bus(1'b1, MIL_OFF_CTRL, 8'h89);
      repeat (3) @(posedge clk_sys_i);
      rd(MIL_OFF_STATUS, 8'h0f);
      chk("irq request", 1, irq);
      chk("takes", 4, takes);
      @(posedge clk_sys_i);
      sleep <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      chk("takes", 5, takes);
      bus(1'b1, MIL_OFF_CTRL, 8'h08);
      repeat (20) @(posedge clk_sys_i);
      rd(MIL_OFF_CTRL, 8'h88);
      repeat (4) @(posedge clk_sys_i);
      test_done();
   end
endmodule // mil_irq_logic_test
`default_nettype wire
